// ===== verilog/fp8_mac.sv
// Top of the 8-bit floating-point multiply-accumulate datapath
`timescale 1ns/1ps
`include "fp8_mac_cfg.svh"

module fp8_mac
(
    input  wire logic                 clk,
    input  wire logic                 rst_b,
    input  wire fp8_mac_pkg::fp8_type operand_a_pin,
    input  wire fp8_mac_pkg::fp8_type operand_b_pin,
    output fp8_mac_pkg::fp8_type      operand_b_out,
    output logic [7:0]                operand_b_oe,
    output fp8_mac_pkg::fp8_type      result
);
    import fp8_mac_pkg::*;

    //--------------------------------------------------------------------------
    // Helpers
    //--------------------------------------------------------------------------
    function automatic fp_parts_type decode(input fp8_type v);
        fp_parts_type p;
        p.sign    = v.sign;
        p.is_nan  = (v.exp == `EXP_ALL_ONES) && (v.man != 2'h0);
        p.is_inf  = (v.exp == `EXP_ALL_ONES) && (v.man == 2'h0);
        p.is_zero = (v.exp == `EXP_SUBNORM) && (v.man == 2'h0);
        // Subnormals share the smallest normal's scale with no hidden one
        p.eff_exp = (v.exp == `EXP_SUBNORM) ? `EXP_SUB_EFF : v.exp;
        p.sig     = {(v.exp != `EXP_SUBNORM), v.man};
        return p;
    endfunction

    // Fixed-point image of an operand in units of the smallest subnormal
    function automatic logic [32:0] align(input fp_parts_type p);
        logic [32:0] x;
        x = {30'h0, p.sig} << (p.eff_exp - `EXP_SUB_EFF);
        return x;
    endfunction

    //--------------------------------------------------------------------------
    // Pin synchronisers
    //--------------------------------------------------------------------------
    fp8_type a_meta_ff;
    fp8_type a_sync_ff;
    fp8_type b_meta_ff;
    fp8_type b_sync_ff;
    fp8_type nxt_a_meta;
    fp8_type nxt_a_sync;
    fp8_type nxt_b_meta;
    fp8_type nxt_b_sync;

    always_comb
    begin
        nxt_a_meta = operand_a_pin;
        nxt_a_sync = a_meta_ff;
        nxt_b_meta = operand_b_pin;
        nxt_b_sync = b_meta_ff;
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            a_meta_ff <= `ACC_RESET;
            a_sync_ff <= `ACC_RESET;
            b_meta_ff <= `ACC_RESET;
            b_sync_ff <= `ACC_RESET;
        end
        else
        begin
            a_meta_ff <= nxt_a_meta;
            a_sync_ff <= nxt_a_sync;
            b_meta_ff <= nxt_b_meta;
            b_sync_ff <= nxt_b_sync;
        end
    end

    //--------------------------------------------------------------------------
    // Multiply stage
    //--------------------------------------------------------------------------
    fp_parts_type pa;
    fp_parts_type pb;
    pack_req_type mul_req;
    fp8_type      mul_packed;
    fp8_type      prod_ff;
    fp8_type      nxt_prod;
    logic [5:0]   mul_sig;

    always_comb
    begin
        pa             = decode(a_sync_ff);
        pb             = decode(b_sync_ff);
        mul_sig        = {3'h0, pa.sig} * {3'h0, pb.sig};
        mul_req.sign   = pa.sign ^ pb.sign;
        mul_req.exp    = $signed({5'h0, pa.eff_exp}) + $signed({5'h0, pb.eff_exp})
                         - `MUL_EXP_SHIFT;
        mul_req.sig    = {28'h0, mul_sig};
    end

    fp8_round_pack u_mul_pack
    (
        .req (mul_req),
        .res (mul_packed)
    );

    always_comb
    begin
        if (pa.is_nan || pb.is_nan)
        begin
            nxt_prod = `NAN_VALUE;
        end
        else if ((pa.is_inf && pb.is_zero) || (pb.is_inf && pa.is_zero))
        begin
            nxt_prod = `NAN_VALUE;
        end
        else if (pa.is_inf || pb.is_inf)
        begin
            nxt_prod = '{sign: mul_req.sign, exp: `EXP_ALL_ONES, man: 2'h0};
        end
        else
        begin
            nxt_prod = mul_packed;
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            prod_ff <= `ACC_RESET;
        end
        else
        begin
            prod_ff <= nxt_prod;
        end
    end

    //--------------------------------------------------------------------------
    // Accumulate stage
    //--------------------------------------------------------------------------
    fp_parts_type pacc;
    fp_parts_type pprd;
    pack_req_type add_req;
    fp8_type      add_packed;
    fp8_type      acc_ff;
    fp8_type      nxt_acc;
    logic [32:0]  x_acc;
    logic [32:0]  x_prd;

    always_comb
    begin
        pacc        = decode(acc_ff);
        pprd        = decode(prod_ff);
        x_acc       = align(pacc);
        x_prd       = align(pprd);
        add_req.exp = `ADD_EXP;
        if (pacc.sign == pprd.sign)
        begin
            add_req.sign = pacc.sign;
            add_req.sig  = {1'b0, x_acc} + {1'b0, x_prd};
        end
        else if (x_acc > x_prd)
        begin
            add_req.sign = pacc.sign;
            add_req.sig  = {1'b0, x_acc - x_prd};
        end
        else
        begin
            // Exact cancellation gives positive zero under nearest-even
            add_req.sign = (x_acc == x_prd) ? 1'b0 : pprd.sign;
            add_req.sig  = {1'b0, x_prd - x_acc};
        end
    end

    fp8_round_pack u_add_pack
    (
        .req (add_req),
        .res (add_packed)
    );

    always_comb
    begin
        if (pacc.is_nan || pprd.is_nan)
        begin
            nxt_acc = `NAN_VALUE;
        end
        else if (pacc.is_inf && pprd.is_inf && (pacc.sign != pprd.sign))
        begin
            nxt_acc = `NAN_VALUE;
        end
        else if (pacc.is_inf)
        begin
            nxt_acc = acc_ff;
        end
        else if (pprd.is_inf)
        begin
            nxt_acc = prod_ff;
        end
        else
        begin
            nxt_acc = add_packed;
        end
    end

    // Loads every cycle; no enable, so the sum keeps running
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            acc_ff <= `ACC_RESET;
        end
        else
        begin
            acc_ff <= nxt_acc;
        end
    end

    //--------------------------------------------------------------------------
    // Pin drivers
    //--------------------------------------------------------------------------
    logic [7:0] b_oe_ff;
    fp8_type    b_out_ff;
    logic [7:0] nxt_b_oe;
    fp8_type    nxt_b_out;

    // Enable high means input here, so operand B pins never drive
    always_comb
    begin
        nxt_b_oe  = `PIN_OE_INPUT;
        nxt_b_out = `PIN_OUT_IDLE;
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            b_oe_ff  <= `PIN_OE_INPUT;
            b_out_ff <= `PIN_OUT_IDLE;
        end
        else
        begin
            b_oe_ff  <= nxt_b_oe;
            b_out_ff <= nxt_b_out;
        end
    end

    assign operand_b_oe  = b_oe_ff;
    assign operand_b_out = b_out_ff;
    assign result        = acc_ff;

endmodule

// ===== verilog/fp8_mac_cfg.svh
// Constants of the 8-bit floating-point multiply-accumulate datapath
//------------------------------------------------------------------------------
// How it works
// - Two operands, each sign, five exponent bits, two mantissa bits.
// - Exponent bias 15; exponent zero means subnormal, no hidden one.
// - All-ones exponent is infinity or NaN; all-zero word is signed zero.
// - Every finite value from smallest subnormal to largest normal is handled.
// - Each accumulate step first multiplies the two operands.
// - The product is added to the partial result in the output register.
// - Output register loads every cycle; result settles after four cycles.
// - Accumulator starts at 0x00, positive zero.
//------------------------------------------------------------------------------
`ifndef FP8_MAC_CFG_SVH
`define FP8_MAC_CFG_SVH

`define EXP_ALL_ONES    5'h1f
`define EXP_SUBNORM     5'h00
`define EXP_SUB_EFF     5'h01
`define EXP_BIAS        10'sd15
`define SIG_MSB         33
`define SIG_W           34
`define NORM_OFFSET     (10'sd33 + `EXP_BIAS)
`define MUL_EXP_SHIFT   10'sd34
`define ADD_EXP         (-10'sd16)
`define ACC_RESET       8'h00
`define NAN_VALUE       8'h7e
`define PIN_OE_INPUT    8'hff
`define PIN_OUT_IDLE    8'h00

`endif

// ===== verilog/fp8_mac_pkg.sv
// Types shared by the multiply-accumulate datapath
package fp8_mac_pkg;

    typedef struct packed {
        logic       sign;
        logic [4:0] exp;
        logic [1:0] man;
    } fp8_type;

    typedef struct packed {
        logic       sign;
        logic       is_nan;
        logic       is_inf;
        logic       is_zero;
        logic [4:0] eff_exp;
        logic [2:0] sig;
    } fp_parts_type;

    // Exact value is sig * 2**exp
    typedef struct packed {
        logic              sign;
        logic signed [9:0] exp;
        logic [33:0]       sig;
    } pack_req_type;

endpackage

// ===== verilog/fp8_round_pack.sv
// Normalise, round to nearest even and pack an exact value into fp8
`timescale 1ns/1ps
`include "fp8_mac_cfg.svh"

module fp8_round_pack
(
    input  fp8_mac_pkg::pack_req_type req,
    output fp8_mac_pkg::fp8_type      res
);
    import fp8_mac_pkg::*;

    logic [33:0]       norm;
    logic [5:0]        lz;
    logic signed [9:0] fe;
    logic signed [9:0] sh;
    logic              sticky;
    logic              guard;
    logic [2:0]        kept;
    logic              inc;
    logic [3:0]        rnd;

    always_comb
    begin
        norm   = req.sig;
        lz     = 6'h00;
        sticky = 1'b0;
        for (int i = 0; i < `SIG_W; i++)
        begin
            if (!norm[`SIG_MSB])
            begin
                norm = norm << 1;
                lz   = lz + 6'h01;
            end
        end
        fe = req.exp + `NORM_OFFSET - $signed({4'h0, lz});
        // Below the normal range: denormalise, keeping lost bits as sticky
        sh = 10'sd1 - fe;
        if (fe < 10'sd1)
        begin
            for (int i = 0; i < `SIG_W; i++)
            begin
                if (10'(i) < sh)
                begin
                    sticky = sticky | norm[0];
                    norm   = norm >> 1;
                end
            end
            fe = 10'sd0;
        end
        kept   = norm[33:31];
        guard  = norm[30];
        sticky = sticky | (|norm[29:0]);
        inc    = guard & (sticky | kept[0]);
        rnd    = {1'b0, kept} + {3'h0, inc};
        if (rnd[3])
        begin
            fe  = fe + 10'sd1;
            rnd = 4'h4;
        end
        if ((fe == 10'sd0) && rnd[2])
        begin
            fe = 10'sd1;                                             // Rounded up into normals
        end
        if (req.sig == 34'h0)
        begin
            res = '{sign: req.sign, exp: `EXP_SUBNORM, man: 2'h0};
        end
        else if (fe >= $signed({5'h0, `EXP_ALL_ONES}))
        begin
            res = '{sign: req.sign, exp: `EXP_ALL_ONES, man: 2'h0};
        end
        else
        begin
            res = '{sign: req.sign, exp: fe[4:0], man: rnd[1:0]};
        end
    end

endmodule

// ===== dv/fp8_mac_properties.sv
// Checker for the fp8 multiply-accumulate top
`timescale 1ns/1ps
module fp8_mac_properties
(
    input wire logic                 clk,
    input wire logic                 rst_b,
    input wire fp8_mac_pkg::fp8_type operand_a_pin,
    input wire fp8_mac_pkg::fp8_type operand_b_pin,
    input wire fp8_mac_pkg::fp8_type operand_b_out,
    input wire logic [7:0]           operand_b_oe,
    input wire fp8_mac_pkg::fp8_type result
);
    import fp8_mac_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);

    // ----
    // Assertions
    // ----
    a_pins_input: assert property (operand_b_oe == 8'hff)
        else $error("two-way pins driven");
    a_out_idle: assert property (operand_b_out == 8'h00)
        else $error("two-way output not idle");
    a_reset_zero: assert property ($rose(rst_b) |-> result == 8'h00)
        else $error("accumulator not zero after reset");
    // Zero product leaves the sum alone, except minus zero turns plus
    a_zero_hold: assert property ((operand_a_pin == 8'h00 && operand_b_pin == 8'h00)
        |-> ##4 (result == $past(result) || ($past(result) == 8'h80 && result == 8'h00)))
        else $error("zero product changed sum");
    a_one_step: assert property ((operand_a_pin == 8'h3c && operand_b_pin == 8'h3c)
        ##3 (result == 8'h00) |=> result == 8'h3c)
        else $error("product not added on time");
    a_nan_input: assert property ((operand_a_pin == 8'h7d) |-> ##4 result == 8'h7e)
        else $error("nan operand lost");
    a_nan_sticky: assert property ((result.exp == 5'h1f && result.man != 2'h0)
        |=> result == 8'h7e)
        else $error("nan not kept");
    a_overflow_inf: assert property ((operand_a_pin == 8'h7b && operand_b_pin == 8'h3c)
        ##3 (result == 8'h7b) |=> result == 8'h7c)
        else $error("overflow not infinity");

    c_nan: cover property (result == 8'h7e);
    c_inf: cover property (result == 8'h7c);
    c_three: cover property (result == 8'h42);
endmodule

bind fp8_mac fp8_mac_properties chk
(
    .clk           (clk),
    .rst_b         (rst_b),
    .operand_a_pin (operand_a_pin),
    .operand_b_pin (operand_b_pin),
    .operand_b_out (operand_b_out),
    .operand_b_oe  (operand_b_oe),
    .result        (result)
);

// ===== dv/operand_host.sv
// Far-side host that presents both operands to the datapath pins
`timescale 1ns/1ps
module operand_host
(
    input  wire fp8_mac_pkg::fp8_type a_val,
    input  wire fp8_mac_pkg::fp8_type b_val,
    input  wire fp8_mac_pkg::fp8_type operand_b_out,
    input  wire logic [7:0]           operand_b_oe,
    output wire fp8_mac_pkg::fp8_type operand_a_pin,
    output wire fp8_mac_pkg::fp8_type operand_b_pin
);
    import fp8_mac_pkg::*;
    assign operand_a_pin = a_val;
    // A bit the design drives wins; a driving design would hide operand B
    assign operand_b_pin = (operand_b_out & ~operand_b_oe) | (b_val & operand_b_oe);
endmodule

// ===== dv/tb_top.sv
// Self-checking bench of the fp8 multiply-accumulate datapath
`timescale 1ns/1ps
module tb_top;
    import fp8_mac_pkg::*;
    logic        clk;
    logic        rst_b = 1'b0;
    fp8_type     a_val = 8'h00;
    fp8_type     b_val = 8'h00;
    wire fp8_type pin_a;
    wire fp8_type pin_b;
    fp8_type     b_out;
    logic [7:0]  b_oe;
    fp8_type     res;
    int          bad_count = 0;
    int          n_compared = 0;
    // Row: operand A, operand B, cycles held, sum from zero
    logic [31:0] rows [19] = '{32'h3c3c013c, 32'h40420146, 32'h3d3d013e, 32'h3e3e0140,
        32'h3d3e0140, 32'h01400102, 32'h01380100, 32'h013a0101, 32'hbc4001c0, 32'h7b3c017b,
        32'h7b40017c, 32'h7c00017e, 32'h7cbc01fc, 32'h7d3c017e, 32'h803c0100, 32'h3c3c0342,
        32'h7b3c027c, 32'h033d0104, 32'h3e3c0344};

    fp8_mac dut (.clk(clk), .rst_b(rst_b), .operand_a_pin(pin_a), .operand_b_pin(pin_b),
        .operand_b_out(b_out), .operand_b_oe(b_oe), .result(res));
    operand_host host (.a_val(a_val), .b_val(b_val), .operand_b_out(b_out),
        .operand_b_oe(b_oe), .operand_a_pin(pin_a), .operand_b_pin(pin_b));

    // ----
    // Helpers
    // ----
    task check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    task end_of_test;
        if (bad_count == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task run(input fp8_type a, input fp8_type b, input int n);
        a_val = a;
        b_val = b;
        repeat (n) @(negedge clk);
    endtask

    task clr;
        @(negedge clk) rst_b = 1'b0;
        @(negedge clk) rst_b = 1'b1;
    endtask

    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // Whole run is a few hundred cycles
    initial
    begin
        #100000;
        bad_count++;
        end_of_test();
    end

    // ----
    // Tests
    // ----
    initial
    begin
        repeat (4) @(negedge clk);
        check(res, 8'h00);
        check(b_oe, 8'hff);
        check(b_out, 8'h00);
        repeat (4) @(negedge clk);
        rst_b = 1'b1;
        foreach (rows[i])
        begin
            clr();
            run(rows[i][31:24], rows[i][23:16], int'(rows[i][15:8]));
            run(8'h00, 8'h00, 5);
            check(res, rows[i][7:0]);
        end
        // Product lands exactly two edges after the synchronised pair
        clr();
        run(8'h3c, 8'h3c, 1);
        run(8'h00, 8'h00, 0);
        for (int i = 0; i < 4; i++)
        begin
            check(res, (i == 3) ? 8'h3c : 8'h00);
            @(negedge clk);
        end
        // Opposite infinities give a nan that later sums keep
        clr();
        run(8'h7c, 8'h3c, 1);
        run(8'hfc, 8'h3c, 1);
        run(8'h3c, 8'h3c, 2);
        run(8'h00, 8'h00, 5);
        check(res, 8'h7e);
        clr();
        run(8'h3c, 8'h3c, 1);
        run(8'hbc, 8'h3c, 1);
        run(8'h00, 8'h00, 5);
        check(res, 8'h00);
        // Reset in mid-accumulation acts at once
        clr();
        run(8'h3c, 8'h3c, 6);
        rst_b = 1'b0;
        run(8'h00, 8'h00, 0);
        #1 check(res, 8'h00);
        @(negedge clk);
        rst_b = 1'b1;
        run(8'h00, 8'h00, 5);
        check(res, 8'h00);
        end_of_test();
    end
endmodule
